// File: common/cicr_params.svh
// Purpose: Constants of the charger interrupt and configuration register slice.
// Assumes: 20 MHz reference clock, two-wire serial register access.
// Notes: Offsets, reset values, field positions and timing counts live here.
// Behaviour
// - Set regulator mask bit blocks alert pin
// - Acknowledged charge interrupt stops driving alert
// - Acknowledged regulator interrupt stops driving alert
// - Charge acknowledge bit clears when condition goes
// - Regulator acknowledge bit clears when condition goes
// - Auto-on zero: valid source forces ON unless supply lockout is set
// - Auto-on one: wait mode stays enabled
// - Charger reset bit clears timers, restarts charging
// - Bit 5 selects taper timer or comparator
// - Bits 4:3 select 25/50/75/100 percent current
// - Bit 2 selects USB 100/500 mA limit
// - Bit 1 permits or blocks USB charging
// - Bit 0 enables charging, wall input preferred
// - Two select bits pick indicator control owner
// - On-time field counts 10 ms steps
// - Select codes: charger, blink, off, on
// - Unmasked, unacknowledged regulator condition pulls alert low
`ifndef CICR_PARAMS_SVH
`define CICR_PARAMS_SVH

`define CICR_OFS_REG_MASK 8'h04
`define CICR_OFS_CHG_ACK 8'h05
`define CICR_OFS_REG_ACK 8'h06
`define CICR_OFS_CFG 8'h07
`define CICR_OFS_ON_TIME 8'h08

`define CICR_RST_REG_MASK 8'hff
`define CICR_RST_ACK 8'h00
`define CICR_RST_CFG 8'h1b
`define CICR_RST_ON_TIME 8'h00

`define CICR_CFG_AUTO_ON 7
`define CICR_CFG_CHG_RESET 6
`define CICR_CFG_TIMER_EN 5
`define CICR_CFG_RATE_HI 4
`define CICR_CFG_RATE_LO 3
`define CICR_CFG_USB_500 2
`define CICR_CFG_USB_ALLOW 1
`define CICR_CFG_CHG_EN 0
`define CICR_ON_SEL_BIT 7

// Serial device address; the value is arbitrary.
`define CICR_DEV_ADDR 7'h48

`define CICR_CLK_PERIOD_NS 50
`define CICR_LED_STEP_MS 10
`define CICR_LED_STEP_CYCLES (`CICR_LED_STEP_MS * 1000000 / `CICR_CLK_PERIOD_NS)
`define CICR_PER_STEP_MS 100
`define CICR_PER_STEPS (`CICR_PER_STEP_MS / `CICR_LED_STEP_MS)

`endif

// File: common/cicr_pkg.sv
// Purpose: Types shared by the register slice.
// Assumes: Constants come from cicr_params.svh.
// Notes: Only types live here.
package cicr_pkg;
    typedef logic [7:0] cicr_byte_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } cicr_state_e;
endpackage : cicr_pkg

// File: core/cicr_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Synchronous active-high reset.
// Notes: Only the second stage is visible outside.
`timescale 1ns/100ps
module cicr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            meta_q <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule : cicr_sync

// File: core/cicr_regs.sv
// Purpose: Interrupt mask/acknowledge, charger configuration and indicator on-time registers.
// Assumes: Status inputs and mask of charge status come from same-clock logic.
// Notes: Registers are reached over the two-wire serial pins only.
`timescale 1ns/100ps
`include "cicr_params.svh"
module cicr_regs import cicr_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `CICR_LED_STEP_CYCLES,
    parameter logic [6:0] DEV_ADDR = `CICR_DEV_ADDR
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    // Status and masks from neighbouring registers
    input wire logic [7:0] charge_status_in,
    input wire logic [7:0] charge_irq_mask_in,
    input wire logic [7:0] regulator_status_in,
    input wire logic charge_status_read_in,
    input wire logic regulator_status_read_in,
    input wire logic indicator_select_high_in,
    input wire logic [6:0] indicator_one_period_in,
    // Charger state
    input wire logic ac_valid_in,
    input wire logic usb_valid_in,
    input wire logic supply_lockout_in,
    input wire logic taper_comparator_in,
    input wire logic taper_timeout_in,
    input wire logic charger_indicator_in,
    // Charger controls
    output logic force_on_out,
    output logic wait_enable_out,
    output logic charger_reset_out,
    output logic fast_timer_enable_out,
    output logic charge_status_bit3_out,
    output logic [6:0] charge_current_pct_out,
    output logic usb_limit_500_out,
    output logic charge_from_ac_out,
    output logic charge_from_usb_out,
    // Alert and indicator open-drain pins
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe_n_out,
    input wire logic charge_indicator_output_in,
    output logic charge_indicator_output_out,
    output logic charge_indicator_output_oe_n_out
);
    logic [1:0] pins_s;
    logic scl_s, sda_s, scl_prev_q, sda_prev_q;
    logic start_w, stop_w, scl_rise_w, scl_fall_w, wr_en_w, sda_drive_w;
    cicr_state_e state_q;
    logic [3:0] cnt_q;
    cicr_byte_t sh_q, ptr_q, tx_q, rd_data_w;
    logic rw_q, nack_q;
    cicr_byte_t reg_mask_q, chg_ack_q, reg_ack_q, cfg_q, on_time_q;
    logic [7:0] chg_pend_w, reg_pend_w;
    logic alert_q;
    logic [17:0] tick_q;
    logic [10:0] phase_q, per_ticks_w, on_ticks_w;
    logic blink_on_w, led_on_d, led_on_q;

    cicr_sync #(.WIDTH(2), .RESET_VAL(2'b11)) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .d_in({scl_in, sda_in}),
        .q_out(pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign start_w = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_w = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    assign scl_rise_w = scl_s && !scl_prev_q;
    assign scl_fall_w = !scl_s && scl_prev_q;
    assign wr_en_w = scl_fall_w && state_q == ST_WR && cnt_q == 4'h8;

    // A start condition restarts the frame from any state, which covers repeated starts.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
        end else if (start_w) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
        end else if (stop_w) begin
            state_q <= ST_IDLE;
        end else if (scl_rise_w) begin
            case (state_q)
                ST_ADDR, ST_REG, ST_WR: begin
                    sh_q <= {sh_q[6:0], sda_s};
                    cnt_q <= cnt_q + 4'h1;
                end
                ST_RD_ACK: nack_q <= sda_s;
                default: ;
            endcase
        end else if (scl_fall_w) begin
            case (state_q)
                ST_ADDR: begin
                    if (cnt_q == 4'h8) begin
                        rw_q <= sh_q[0];
                        state_q <= (sh_q[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_q <= 4'h0;
                    tx_q <= rd_data_w;
                    state_q <= rw_q ? ST_RD : ST_REG;
                end
                ST_REG: begin
                    if (cnt_q == 4'h8) begin
                        ptr_q <= sh_q;
                        state_q <= ST_REG_ACK;
                    end
                end
                ST_REG_ACK, ST_WR_ACK: begin
                    cnt_q <= 4'h0;
                    state_q <= ST_WR;
                end
                ST_WR: begin
                    if (cnt_q == 4'h8) begin
                        state_q <= ST_WR_ACK;
                    end
                end
                ST_RD: begin
                    if (cnt_q == 4'h7) begin
                        state_q <= ST_RD_ACK;
                    end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_RD_ACK: begin
                    cnt_q <= 4'h0;
                    tx_q <= rd_data_w;
                    state_q <= nack_q ? ST_IDLE : ST_RD;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_comb begin
        case (ptr_q)
            `CICR_OFS_REG_MASK: rd_data_w = reg_mask_q;
            `CICR_OFS_CHG_ACK: rd_data_w = chg_ack_q;
            `CICR_OFS_REG_ACK: rd_data_w = reg_ack_q;
            `CICR_OFS_CFG: rd_data_w = cfg_q;
            `CICR_OFS_ON_TIME: rd_data_w = on_time_q;
            default: rd_data_w = 8'h00;
        endcase
    end

    // SDA is re-timed by one clock so it changes well after SCL has fallen.
    assign sda_drive_w = state_q == ST_ADDR_ACK || state_q == ST_REG_ACK
        || state_q == ST_WR_ACK || (state_q == ST_RD && !tx_q[7]);
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sda_oe_n_out <= 1'b1;
        end else begin
            sda_oe_n_out <= !sda_drive_w;
        end
    end
    assign sda_out = 1'b0;

    // Acknowledge registers are not writable; their writes are dropped.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            reg_mask_q <= `CICR_RST_REG_MASK;
            cfg_q <= `CICR_RST_CFG;
            on_time_q <= `CICR_RST_ON_TIME;
        end else if (wr_en_w) begin
            case (ptr_q)
                `CICR_OFS_REG_MASK: reg_mask_q <= sh_q;
                `CICR_OFS_CFG: cfg_q <= sh_q;
                `CICR_OFS_ON_TIME: on_time_q <= sh_q;
                default: ;
            endcase
        end
    end

    // Pending bits; the regulator register itself cannot pend again until
    // its condition falls and rises, because the acknowledge only clears then.
    assign chg_pend_w = charge_status_in & ~charge_irq_mask_in & ~chg_ack_q;
    assign reg_pend_w = regulator_status_in & ~reg_mask_q & ~reg_ack_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            chg_ack_q <= `CICR_RST_ACK;
            reg_ack_q <= `CICR_RST_ACK;
        end else begin
            chg_ack_q <= (chg_ack_q | (charge_status_read_in ? chg_pend_w : 8'h00))
                & charge_status_in;
            reg_ack_q <= (reg_ack_q | (regulator_status_read_in ? reg_pend_w : 8'h00))
                & regulator_status_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= |{chg_pend_w, reg_pend_w};
        end
    end
    assign alert_out = 1'b0;
    assign alert_oe_n_out = !alert_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            force_on_out <= 1'b0;
            wait_enable_out <= 1'b1;
            charger_reset_out <= 1'b0;
            fast_timer_enable_out <= 1'b0;
            charge_status_bit3_out <= 1'b0;
            charge_current_pct_out <= 7'h00;
            usb_limit_500_out <= 1'b0;
            charge_from_ac_out <= 1'b0;
            charge_from_usb_out <= 1'b0;
        end else begin
            force_on_out <= !cfg_q[`CICR_CFG_AUTO_ON] && (ac_valid_in || usb_valid_in)
                && !supply_lockout_in;
            wait_enable_out <= cfg_q[`CICR_CFG_AUTO_ON] || !(ac_valid_in || usb_valid_in)
                || supply_lockout_in;
            charger_reset_out <= cfg_q[`CICR_CFG_CHG_RESET];
            fast_timer_enable_out <= cfg_q[`CICR_CFG_TIMER_EN];
            charge_status_bit3_out <= cfg_q[`CICR_CFG_TIMER_EN] ? taper_timeout_in
                : taper_comparator_in;
            case (cfg_q[`CICR_CFG_RATE_HI:`CICR_CFG_RATE_LO])
                2'b11: charge_current_pct_out <= 7'h64;
                2'b10: charge_current_pct_out <= 7'h4b;
                2'b01: charge_current_pct_out <= 7'h32;
                default: charge_current_pct_out <= 7'h19;
            endcase
            usb_limit_500_out <= cfg_q[`CICR_CFG_USB_ALLOW] && cfg_q[`CICR_CFG_USB_500];
            charge_from_ac_out <= cfg_q[`CICR_CFG_CHG_EN] && ac_valid_in;
            charge_from_usb_out <= cfg_q[`CICR_CFG_CHG_EN] && cfg_q[`CICR_CFG_USB_ALLOW]
                && usb_valid_in && !ac_valid_in;
        end
    end

    // Indicator blink: a count of n gives (n + 1) steps, so a zero field is the minimum.
    assign per_ticks_w = 11'(({4'h0, indicator_one_period_in} + 11'h001)
        * 11'(`CICR_PER_STEPS));
    assign on_ticks_w = {4'h0, on_time_q[6:0]} + 11'h001;
    assign blink_on_w = phase_q < on_ticks_w;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            tick_q <= 18'h00000;
            phase_q <= 11'h000;
        end else if (tick_q == 18'(TICK_CYCLES - 1)) begin
            tick_q <= 18'h00000;
            phase_q <= (phase_q + 11'h001 >= per_ticks_w) ? 11'h000 : phase_q + 11'h001;
        end else begin
            tick_q <= tick_q + 18'h00001;
        end
    end

    always_comb begin
        case ({on_time_q[`CICR_ON_SEL_BIT], indicator_select_high_in})
            2'b00: led_on_d = charger_indicator_in;
            2'b01: led_on_d = blink_on_w;
            2'b10: led_on_d = 1'b0;
            default: led_on_d = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            led_on_q <= 1'b0;
        end else begin
            led_on_q <= led_on_d;
        end
    end
    assign charge_indicator_output_out = 1'b0;
    assign charge_indicator_output_oe_n_out = !led_on_q;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);

    chk_mask_quiet:
    assert property ((chg_pend_w == 8'h00 && (regulator_status_in & ~reg_mask_q) == 8'h00)
        |=> alert_oe_n_out) else $error("masked condition drove alert");
    chk_chg_ack_take:
    assert property (charge_status_read_in |=> (chg_ack_q & $past(chg_pend_w))
        == $past(chg_pend_w)) else $error("charge ack not taken");
    chk_reg_ack_take:
    assert property (regulator_status_read_in |=> (reg_ack_q & $past(reg_pend_w))
        == $past(reg_pend_w)) else $error("regulator ack not taken");
    chk_chg_ack_clear:
    assert property (1'b1 |=> (chg_ack_q & ~$past(charge_status_in)) == 8'h00)
        else $error("charge ack kept after condition left");
    chk_reg_ack_clear:
    assert property (1'b1 |=> (reg_ack_q & ~$past(regulator_status_in)) == 8'h00)
        else $error("regulator ack kept after condition left");
    chk_auto_on_force:
    assert property ((!cfg_q[7] && ac_valid_in && !supply_lockout_in)
        |=> force_on_out && !wait_enable_out) else $error("auto-on did not force on");
    chk_auto_on_wait:
    assert property (cfg_q[7] |=> wait_enable_out && !force_on_out)
        else $error("wait mode lost with auto-on set");
    chk_chg_reset:
    assert property ($rose(cfg_q[6]) |=> charger_reset_out ##1 $stable(charger_reset_out)
        || !cfg_q[6]) else $error("charger reset not driven");
    chk_rate_75:
    assert property (cfg_q[4:3] == 2'b10 |=> charge_current_pct_out == 7'h4b)
        else $error("rate code 10 not 75 percent");
    chk_usb_ignore:
    assert property (!cfg_q[1] |=> !usb_limit_500_out && !charge_from_usb_out)
        else $error("usb limit used while usb charging blocked");
    chk_ac_pref:
    assert property ((cfg_q[0] && ac_valid_in && usb_valid_in)
        |=> charge_from_ac_out && !charge_from_usb_out) else $error("wall input not preferred");
    chk_alert_pend:
    assert property ((chg_pend_w != 8'h00 || reg_pend_w != 8'h00) |=> !alert_oe_n_out)
        else $error("pending interrupt did not pull alert");

    cov_cfg_write: cover property (wr_en_w && ptr_q == `CICR_OFS_CFG);
    cov_read_byte: cover property (state_q == ST_RD_ACK && scl_fall_w);
    cov_alert_low: cover property (!alert_oe_n_out && !alert_in);
    cov_blink: cover property ($fell(charge_indicator_output_oe_n_out) && on_time_q[7] == 1'b0
        && indicator_select_high_in && !charge_indicator_output_in);
endmodule : cicr_regs

// File: verif/cicr_host_model.sv
// Purpose: Host processor model driving the two-wire register bus.
// Assumes: SCL high and low phases of 4 reference clocks each, 400 ns period.
// Notes: Pins change one clock after an edge; the bus stands idle between frames.
`timescale 1ns/100ps
`include "cicr_params.svh"
module cicr_host_model #(
    parameter logic [6:0] DEV_ADDR = `CICR_DEV_ADDR
) (
    // Clock
    input wire logic ref_clk_in,
    // Serial bus, low enable pulls SDA low
    input wire logic sda_line_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : tick

    // Data is sampled mid-high, well clear of the device's answer delay.
    task automatic bit_xfer(input logic tx, output logic rx);
        tick(1);
        sda_oe_n_out <= tx;
        tick(3);
        scl_out <= 1'b1;
        tick(2);
        rx = sda_line_in;
        tick(2);
        scl_out <= 1'b0;
    endtask : bit_xfer

    task automatic start_cond();
        tick(4);
        sda_oe_n_out <= 1'b0;
        tick(4);
        scl_out <= 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        tick(1);
        sda_oe_n_out <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(4);
        sda_oe_n_out <= 1'b1;
        tick(4);
    endtask : stop_cond

    task automatic byte_out(input logic [7:0] b, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, nack);
    endtask : byte_out

    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                      output logic ok);
        logic n1, n2, n3;
        start_cond();
        byte_out({dev, 1'b0}, n1);
        byte_out(a, n2);
        byte_out(d, n3);
        stop_cond();
        ok = !(n1 | n2 | n3);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic n1, n2, n3, r;
        start_cond();
        byte_out({DEV_ADDR, 1'b0}, n1);
        byte_out(a, n2);
        tick(1);
        tick(3);
        scl_out <= 1'b1;
        start_cond();
        byte_out({DEV_ADDR, 1'b1}, n3);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(1'b1, r);
        stop_cond();
        ok = !(n1 | n2 | n3);
    endtask : rd
endmodule : cicr_host_model

// File: verif/charger_irq_config_regs_tb.sv
// Purpose: Self-checking bench of the charger interrupt and configuration registers.
// Assumes: TICK_CYCLES is 20 so a blink period with a zero period field lasts 200 clocks.
// Notes: Expectations come from bench functions, never from the design.
`timescale 1ns/100ps
`include "cicr_params.svh"
module charger_irq_config_regs_tb;
    logic clk = 1'b0;
    logic srst_in = 1'b1;
    logic scl, host_oe_n, sda_o, sda_oe_n, alert_o, alert_oe_n, ind_o, ind_oe_n;
    logic [7:0] chg_stat = 8'h00, chg_mask = 8'hff, reg_stat = 8'h00;
    logic chg_rd = 1'b0, reg_rd = 1'b0, sel_hi = 1'b0, chg_ind = 1'b0;
    logic ac = 1'b0, usb = 1'b0, lock = 1'b0, tc = 1'b0, tt = 1'b0;
    logic fo, we, cr, fte, b3, u500, fac, fusb, ok;
    logic [6:0] pct, per = 7'h00;
    logic [7:0] c;
    logic [31:0] seed = 32'h9e80;
    int checks = 0, n_mismatch = 0, n;
    wire sda_line = host_oe_n & (sda_oe_n | sda_o);
    wire [7:0] ctl = {fo, we, cr, fte, b3, u500, fac, fusb};
    logic [7:0] rst_ofs [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0f};
    logic [7:0] rst_val [6] = '{8'hff, 8'h00, 8'h00, 8'h1b, 8'h00, 8'h00};
    logic [7:0] corner [5] = '{8'h4b, 8'h1b, 8'h00, 8'hff, 8'hb4};

    always #25 clk = ~clk;

    cicr_host_model i_cicr_host_model (.ref_clk_in(clk), .sda_line_in(sda_line),
        .scl_out(scl), .sda_oe_n_out(host_oe_n));

    cicr_regs #(.TICK_CYCLES(20)) i_cicr_regs (.ref_clk_in(clk), .srst_in(srst_in),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .charge_status_in(chg_stat), .charge_irq_mask_in(chg_mask),
        .regulator_status_in(reg_stat), .charge_status_read_in(chg_rd),
        .regulator_status_read_in(reg_rd), .indicator_select_high_in(sel_hi),
        .indicator_one_period_in(per), .ac_valid_in(ac), .usb_valid_in(usb),
        .supply_lockout_in(lock), .taper_comparator_in(tc), .taper_timeout_in(tt),
        .charger_indicator_in(chg_ind), .force_on_out(fo), .wait_enable_out(we),
        .charger_reset_out(cr), .fast_timer_enable_out(fte),
        .charge_status_bit3_out(b3), .charge_current_pct_out(pct),
        .usb_limit_500_out(u500), .charge_from_ac_out(fac), .charge_from_usb_out(fusb),
        .alert_in(alert_oe_n | alert_o), .alert_out(alert_o),
        .alert_oe_n_out(alert_oe_n), .charge_indicator_output_in(ind_oe_n | ind_o),
        .charge_indicator_output_out(ind_o), .charge_indicator_output_oe_n_out(ind_oe_n));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [7:0] exp_ctl(input logic [7:0] v);
        logic f;
        f = !v[7] && (ac || usb) && !lock;
        return {f, !f, v[6], v[5], v[5] ? tt : tc, v[2] & v[1], v[0] & ac,
                v[0] & v[1] & usb & !ac};
    endfunction : exp_ctl

    function automatic logic [7:0] exp_pct(input logic [1:0] r);
        logic [7:0] t [4] = '{8'h19, 8'h32, 8'h4b, 8'h64};
        return t[r];
    endfunction : exp_pct

    // One step is 20 clocks here; a blink period lasts (period + 1) times ten steps.
    function automatic int exp_lit(input int on, input int p, input int win);
        return win / ((p + 1) * `CICR_PER_STEPS * 20) * (on + 1) * 20;
    endfunction : exp_lit

    task automatic compare(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : compare

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_cicr_host_model.rd(a, d, ok);
        compare("read ack", 8'h01, {7'h00, ok});
        compare($sformatf("register %h", a), e, d);
    endtask : chk_reg

    task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
        compare(nm, e, g);
    endtask : chk_pin

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        i_cicr_host_model.wr(`CICR_DEV_ADDR, a, d, ok);
        compare("write ack", 8'h01, {7'h00, ok});
    endtask : reg_wr

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic pulse(input bit reg_side);
        @(posedge clk);
        if (reg_side) reg_rd <= 1'b1;
        else chg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        chg_rd <= 1'b0;
        settle(3);
    endtask : pulse

    // The window is a whole number of periods, so its start phase does not matter.
    task automatic count_lit(input logic [6:0] p, output int k);
        @(posedge clk);
        per <= p;
        settle(450);
        k = 0;
        repeat (400) begin
            @(negedge clk);
            if (ind_oe_n === 1'b0) k++;
        end
    endtask : count_lit

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // A hang anywhere counts against the run instead of stalling it.
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk);
        srst_in <= 1'b0;
        settle(4);
        chk_pin("current", exp_pct(2'b11), {1'b0, pct});
        chk_pin("controls", exp_ctl(8'h1b), ctl);
        foreach (rst_ofs[i]) chk_reg(rst_ofs[i], rst_val[i]);
        $display("test reset done");
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            c = (i < 5) ? corner[i] : (i == 13) ? 8'h1b : seed[15:8];
            @(posedge clk);
            {ac, usb, lock, tc, tt} <= seed[4:0];
            reg_wr(8'h07, c);
            settle(3);
            chk_pin("controls", exp_ctl(c), ctl);
            chk_pin("current", exp_pct(c[4:3]), {1'b0, pct});
            chk_reg(8'h07, c);
        end
        i_cicr_host_model.wr(`CICR_DEV_ADDR ^ 7'h01, 8'h07, 8'h00, ok);
        chk_pin("foreign ack", 8'h00, {7'h00, ok});
        chk_reg(8'h07, 8'h1b);
        $display("test configuration done");
        @(posedge clk);
        reg_stat <= 8'h84;
        settle(3);
        chk_pin("alert masked", 8'h01, {7'h00, alert_oe_n});
        reg_wr(8'h04, 8'hfb);
        settle(2);
        chk_pin("alert", 8'h00, {7'h00, alert_oe_n});
        @(posedge clk);
        chg_mask <= 8'hfe;
        chg_stat <= 8'h41;
        pulse(1'b0);
        chk_pin("alert held", 8'h00, {7'h00, alert_oe_n});
        chk_reg(8'h05, 8'h01);
        pulse(1'b1);
        chk_pin("alert free", 8'h01, {7'h00, alert_oe_n});
        reg_wr(8'h06, 8'hff);
        chk_reg(8'h06, 8'h04);
        reg_stat <= 8'h00;
        chg_stat <= 8'h00;
        settle(3);
        chk_reg(8'h06, 8'h00);
        chk_reg(8'h05, 8'h00);
        reg_stat <= 8'h04;
        settle(3);
        chk_pin("alert again", 8'h00, {7'h00, alert_oe_n});
        @(posedge clk);
        reg_stat <= 8'h00;
        $display("test interrupts done");
        chg_ind <= 1'b1;
        reg_wr(8'h08, 8'h01);
        settle(2);
        chk_pin("indicator charger", 8'h00, {7'h00, ind_oe_n});
        reg_wr(8'h08, 8'h81);
        settle(2);
        chk_pin("indicator off", 8'h01, {7'h00, ind_oe_n});
        @(posedge clk);
        sel_hi <= 1'b1;
        settle(2);
        chk_pin("indicator on", 8'h00, {7'h00, ind_oe_n});
        reg_wr(8'h08, 8'h01);
        count_lit(7'h00, n);
        chk_pin("lit cycles", 8'(exp_lit(1, 0, 400)), 8'(n));
        reg_wr(8'h08, 8'h03);
        count_lit(7'h01, n);
        chk_pin("lit cycles long", 8'(exp_lit(3, 1, 400)), 8'(n));
        $display("test indicator done");
        end_sim();
    end
endmodule : charger_irq_config_regs_tb
